// File: rtl/mbs_seq.sv
// max-mode bus cycle sequencer: state, status, ack pair, request/grant
`timescale 1ns/1ps
module mbs_seq (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // bus cycle request from core
  input  wire logic       cyc_req,
  input  wire logic [2:0] cyc_status,
  input  wire logic [2:0] cascade_in,
  // asynchronous pins
  input  wire logic       ready,
  input  wire logic       maskable_interrupt_request,
  input  wire logic       nmi,
  input  wire logic       wait_test_input,
  // request/grant pin
  input  wire logic       request_grant_line_i,
  output logic            request_grant_line_o,
  output logic            request_grant_line_oe_n,
  // bus outputs
  output logic [2:0]      status,
  output logic            ad_oe_n,
  output logic [2:0]      cascade_addr,
  output logic            cascade_valid,
  output logic            cyc_done,
  output logic            nmi_seen,
  output logic            test_seen
);

  // ***************************************************
  // synchronisers
  // ***************************************************
  logic [4:0] sy1_q, sy2_q;
  logic       rg_prev_q, own1_q, own2_q;
  logic       rgo_q, rgoe_q;
  logic       rg_s;
  // own low drive on the line is masked, its echo is no release
  assign rg_s = sy2_q[4] | own2_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sy1_q     <= 5'h1D; // interrupt request input idles low, others high
      sy2_q     <= 5'h1D;
      rg_prev_q <= 1'b1;
      own1_q    <= 1'b0;
      own2_q    <= 1'b0;
    end else begin
      sy1_q     <= {request_grant_line_i, wait_test_input, nmi,
                    maskable_interrupt_request, ready};
      sy2_q     <= sy1_q;
      rg_prev_q <= rg_s;
      own1_q    <= ~rgoe_q & ~rgo_q;
      own2_q    <= own1_q;
    end
  end
  logic rdy_s, maskable_interrupt_request_s, rg_pulse;
  assign rdy_s    = sy2_q[0];
  assign maskable_interrupt_request_s   = sy2_q[1];
  assign rg_pulse = rg_prev_q & ~rg_s;

  // ***************************************************
  // bus cycle sequencer
  // ***************************************************
  mbs_pkg::mbs_state_e st_q, st_d;
  mbs_pkg::mbs_rg_e    rg_q, rg_d;
  logic [1:0] ack_q, ack_d;
  logic [2:0] stat_q, stat_d, cas_q, cas_d;
  logic       adz_q, adz_d, casv_q, casv_d, done_q, done_d;
  logic       nmi_q, nmi_d, tst_q, tst_d, rgo_d, rgoe_d;
  logic       bus_free;

  assign bus_free = (rg_q == mbs_pkg::MBS_RG_IDLE);

  // next state of cycle, status and ack pair
  always_comb begin
    st_d   = st_q;
    ack_d  = ack_q;
    stat_d = stat_q;
    cas_d  = cas_q;
    adz_d  = adz_q;
    casv_d = casv_q;
    done_d = 1'b0;
    nmi_d  = ~sy2_q[2];
    tst_d  = ~sy2_q[3];
    case (st_q)
      mbs_pkg::MBS_TI: begin
        if (bus_free && (maskable_interrupt_request_s || ack_q != mbs_pkg::MBS_ACK_RST)) begin
          st_d   = mbs_pkg::MBS_T1;
          stat_d = mbs_pkg::MBS_STATUS_INTERRUPT_ACKNOWLEDGE_CYCLE;
          adz_d  = 1'b1;
          if (ack_q == mbs_pkg::MBS_ACK_RST)
            ack_d = mbs_pkg::MBS_ACK_CNT;
        end else if (bus_free && cyc_req) begin
          st_d   = mbs_pkg::MBS_T1;
          stat_d = cyc_status;
          adz_d  = 1'b0;
        end
      end
      mbs_pkg::MBS_T1: st_d = mbs_pkg::MBS_T2;
      mbs_pkg::MBS_T2: st_d = mbs_pkg::MBS_T3;
      mbs_pkg::MBS_T3, mbs_pkg::MBS_TW: begin
        if (rdy_s) begin
          st_d   = mbs_pkg::MBS_T4;
          stat_d = mbs_pkg::MBS_STATUS_PASSIVE;
        end else begin
          st_d = mbs_pkg::MBS_TW;
        end
      end
      default: begin
        done_d = 1'b1;
        if (ack_q != mbs_pkg::MBS_ACK_RST) begin
          ack_d = ack_q - 2'h1;
          casv_d = (ack_q == mbs_pkg::MBS_ACK_CNT);
          if (ack_q == mbs_pkg::MBS_ACK_CNT)
            cas_d = cascade_in;
          if (ack_q == mbs_pkg::MBS_ACK_CNT) begin
            st_d   = mbs_pkg::MBS_T1;
            stat_d = mbs_pkg::MBS_STATUS_INTERRUPT_ACKNOWLEDGE_CYCLE;
          end else begin
            st_d  = mbs_pkg::MBS_TI;
            adz_d = 1'b0;
          end
        end else begin
          st_d = mbs_pkg::MBS_TI;
        end
      end
    endcase
    // cascade address dropped at the end of T2 of second cycle
    if (st_q == mbs_pkg::MBS_T2 && casv_q)
      casv_d = 1'b0;
  end

  // next state of request/grant
  always_comb begin
    rg_d   = rg_q;
    rgo_d  = 1'b1;
    rgoe_d = 1'b1;
    case (rg_q)
      mbs_pkg::MBS_RG_IDLE:
        if (rg_pulse && st_q == mbs_pkg::MBS_TI) begin
          rg_d   = mbs_pkg::MBS_RG_GRANT;
          rgo_d  = 1'b0;
          rgoe_d = 1'b0;
        end
      // grant pulse lasts one clock
      mbs_pkg::MBS_RG_GRANT: rg_d = mbs_pkg::MBS_RG_OWNED;
      // coprocessor owns bus until release pulse
      mbs_pkg::MBS_RG_OWNED:
        if (rg_pulse) begin
          rg_d   = mbs_pkg::MBS_RG_DRIVE;
          rgo_d  = 1'b1;
          rgoe_d = 1'b0;
        end
      default: rg_d = mbs_pkg::MBS_RG_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q   <= mbs_pkg::MBS_TI;
      rg_q   <= mbs_pkg::MBS_RG_IDLE;
      ack_q  <= mbs_pkg::MBS_ACK_RST;
      stat_q <= mbs_pkg::MBS_STATUS_PASSIVE;
      cas_q  <= mbs_pkg::MBS_CASCADE_RST;
      adz_q  <= 1'b0;
      casv_q <= 1'b0;
      done_q <= 1'b0;
      nmi_q  <= 1'b0;
      tst_q  <= 1'b0;
      rgo_q  <= 1'b1;
      rgoe_q <= 1'b1;
    end else begin
      st_q   <= st_d;
      rg_q   <= rg_d;
      ack_q  <= ack_d;
      stat_q <= stat_d;
      cas_q  <= cas_d;
      adz_q  <= adz_d;
      casv_q <= casv_d;
      done_q <= done_d;
      nmi_q  <= nmi_d;
      tst_q  <= tst_d;
      rgo_q  <= rgo_d;
      rgoe_q <= rgoe_d;
    end
  end

  assign status                  = stat_q;
  assign ad_oe_n                 = adz_q;
  assign cascade_addr            = cas_q;
  assign cascade_valid           = casv_q;
  assign cyc_done                = done_q;
  assign nmi_seen                = nmi_q;
  assign test_seen               = tst_q;
  assign request_grant_line_o    = rgo_q;
  assign request_grant_line_oe_n = rgoe_q;

endmodule : mbs_seq

// File: rtl/mbs_pkg.sv
// constants and types for the max-mode bus cycle sequencer
// Function
// - sample ready at T3 and wait states; stretch
// - status passive all-ones from the start of T4
// - drive request_grant_line high after pulse exchange
// - two back-to-back acknowledge cycles, bus floating
// - cascade address valid in T1 and T2 of second acknowledge cycle
// - async inputs two-flop synchronised, acted on third clock
package mbs_pkg;

  // ***************************************************
  // bus cycle states
  // ***************************************************
  typedef enum logic [2:0] {
    MBS_TI = 3'b000,
    MBS_T1 = 3'b001,
    MBS_T2 = 3'b010,
    MBS_T3 = 3'b011,
    MBS_TW = 3'b100,
    MBS_T4 = 3'b101
  } mbs_state_e;

  // ***************************************************
  // request/grant states
  // ***************************************************
  typedef enum logic [1:0] {
    MBS_RG_IDLE  = 2'b00,
    MBS_RG_GRANT = 2'b01,
    MBS_RG_OWNED = 2'b10,
    MBS_RG_DRIVE = 2'b11
  } mbs_rg_e;

  localparam logic [2:0] MBS_STATUS_PASSIVE = 3'h7;
  localparam logic [2:0] MBS_STATUS_INTERRUPT_ACKNOWLEDGE_CYCLE    = 3'h0;
  localparam logic [2:0] MBS_CASCADE_RST    = 3'h0;
  localparam logic [1:0] MBS_ACK_CNT        = 2'h2;
  localparam logic [1:0] MBS_ACK_RST        = 2'h0;

endpackage : mbs_pkg

// File: test/mbs_props.sv
// checker for the bus cycle sequencer ports
`timescale 1ns/1ps
module mbs_props (
  input wire logic       core_clk, rstn, ready, nmi, wait_test_input,
  input wire logic       request_grant_line_o, request_grant_line_oe_n,
  input wire logic       ad_oe_n, cascade_valid, cyc_done,
  input wire logic       nmi_seen, test_seen,
  input wire logic [2:0] status
);
  localparam logic [2:0] P = mbs_pkg::MBS_STATUS_PASSIVE;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_pass_t4: assert property (cyc_done |-> $past(status) == P)
    else $error("status not passive before done");
  chk_t1_kind: assert property (cyc_done |-> $past(status, 2) != P)
    else $error("status dropped early");
  chk_wait_hold: assert property ((status != P && !ready)[*3]
    |=> status != P) else $error("no wait inserted");
  chk_rg_drive: assert property (!request_grant_line_oe_n
    |=> request_grant_line_oe_n) else $error("grant drive too long");
  chk_ack_float: assert property (status == mbs_pkg::MBS_STATUS_INTERRUPT_ACKNOWLEDGE_CYCLE
    |-> ad_oe_n) else $error("bus driven in ack");
  chk_casc_float: assert property ($rose(cascade_valid) |-> ad_oe_n)
    else $error("cascade outside ack pair");
  chk_nmi_sync: assert property ((!nmi)[*4] |-> nmi_seen)
    else $error("nmi not seen");
  chk_test_sync: assert property ((!wait_test_input)[*4] |-> test_seen)
    else $error("test not seen");
  cover property (cyc_done);
  cover property ($rose(cascade_valid));
  cover property (!request_grant_line_oe_n && request_grant_line_o);
endmodule : mbs_props
bind mbs_seq mbs_props chk_u (.*);

// File: test/mbs_far.sv
// far side model: ready source and bus-sharing coprocessor
`timescale 1ns/1ps
module mbs_far (
  input  wire logic       core_clk, rstn, ld, rq, rg_o, rg_oe_n,
  input  wire logic [2:0] stall,
  output logic            ready, rg_i
);
  logic [2:0] cnt_q;
  logic       low_q;
  // ready held low for stall cycles
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) cnt_q <= 3'h0;
    else cnt_q <= ld ? stall : cnt_q - {2'h0, cnt_q != 3'h0};
  end
  always_ff @(posedge core_clk) low_q <= rq;
  assign ready = cnt_q == 3'h0;
  // coprocessor pulls low only while released
  assign rg_i = !rg_oe_n ? rg_o : !low_q;
endmodule : mbs_far

// File: test/testbench.sv
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
module testbench;
  logic core_clk, rstn, cyc_req, mir, nmi, tst, ld, rq, ready, rg_i, rg_o;
  logic rg_oe_n, ad_oe_n, cascade_valid, cyc_done, nmi_seen, test_seen;
  logic [2:0] cyc_status, cascade_in, status, cascade_addr, stall;
  int fail_count, check_count, cyc;
  mbs_seq dut_u (.core_clk(core_clk), .rstn(rstn), .cyc_req(cyc_req),
    .cyc_status(cyc_status), .cascade_in(cascade_in), .ready(ready),
    .maskable_interrupt_request(mir), .nmi(nmi), .wait_test_input(tst),
    .request_grant_line_i(rg_i), .request_grant_line_o(rg_o),
    .request_grant_line_oe_n(rg_oe_n), .status(status), .ad_oe_n(ad_oe_n),
    .cascade_addr(cascade_addr), .cascade_valid(cascade_valid),
    .cyc_done(cyc_done), .nmi_seen(nmi_seen), .test_seen(test_seen));
  mbs_far far_u (.core_clk(core_clk), .rstn(rstn), .ld(ld), .rq(rq),
    .rg_o(rg_o), .rg_oe_n(rg_oe_n), .stall(stall), .ready(ready),
    .rg_i(rg_i));
  always #12.5 core_clk = ~core_clk;
  task end_sim;
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // waits at falling edges for a level, returns edges taken
  task automatic wt(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 40) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wt
  task t_cycle(input logic [2:0] st);
    int n;
    logic [2:0] prev;
    @(negedge core_clk);
    {stall, ld, cyc_req, cyc_status} = {st, 2'b11, 3'h4};
    @(negedge core_clk);
    ld = 0;
    @(negedge core_clk);
    chk(status, 3'h4);
    repeat (2 + st) @(negedge core_clk);
    prev = status;
    wt(cyc_done, 1'b1, n);
    cyc_req = 0;
    chk(prev, 3'h7);
    chk(n + 4 + st, 5 + st);
  endtask : t_cycle
  task t_ack;
    int n;
    @(negedge core_clk);
    {cascade_in, mir} = {3'h5, 1'b1};
    wt(cascade_valid, 1'b1, n);
    mir = 0;
    chk(cascade_addr, 3'h5);
    chk(ad_oe_n, 1'b1);
    wt(cyc_done, 1'b0, n);
    chk(ad_oe_n, 1'b1);
    wt(cyc_done, 1'b1, n);
    chk(cascade_valid, 1'b0);
  endtask : t_ack
  task t_grant(input logic lv);
    int n;
    @(negedge core_clk);
    rq = 1;
    @(negedge core_clk);
    rq = 0;
    wt(rg_oe_n, 1'b0, n);
    chk(rg_o, lv);
    wt(rg_oe_n, 1'b1, n);
  endtask : t_grant
  task t_async(input logic lv);
    @(negedge core_clk);
    {nmi, tst} = {2{lv}};
    repeat (3) @(negedge core_clk);
    chk({nmi_seen, test_seen}, {2{!lv}});
  endtask : t_async
  initial begin
    {core_clk, rstn, cyc_req, mir, ld, rq, stall, cyc_status} = 0;
    {nmi, tst, cascade_in} = {2'b11, 3'h0};
    repeat (8) @(negedge core_clk);
    rstn = 1;
    repeat (3) @(negedge core_clk);
    t_cycle(3'h0);
    t_cycle(3'h1);
    t_cycle(3'h3);
    t_ack();
    t_grant(1'b0);
    t_grant(1'b1);
    t_async(1'b0);
    t_async(1'b1);
    end_sim();
  end
endmodule : testbench
